/* File: common/seesp_map.svh */
/*
 Constants of the serial EEPROM front end: opcode encodings, bit-count limits and zero values.
 Assumes inclusion from the package and the design file only.
*/
`ifndef SEESP_MAP_SVH
`define SEESP_MAP_SVH
`define SEESP_OP_SET_WL 8'h06
`define SEESP_OP_CLR_WL 8'h04
`define SEESP_OP_STAT_FETCH 8'h05
`define SEESP_OP_STAT_UPDATE 8'h01
`define SEESP_OP_READ 8'h03
`define SEESP_OP_WRITE 8'h02
`define SEESP_BYTE_LAST 3'h7
`define SEESP_CNT_ZERO 3'h0
`define SEESP_BYTE_ZERO 8'h00
`endif

/* File: common/seesp_pkg.sv */
/*
 Types of the serial EEPROM front end.
 Assumes seesp_map.svh sits in the include path.
*/
`include "seesp_map.svh"
package seesp_pkg;
    // Frame phase, Gray coded along idle -> opcode -> active -> wait
    typedef enum logic [1:0] {
        SEESP_IDLE = 2'b00,
        SEESP_OPC = 2'b01,
        SEESP_ACT = 2'b11,
        SEESP_WAIT = 2'b10
    } seesp_phase_t;
    typedef enum logic [2:0] {
        SEESP_CMD_NONE = 3'h0,
        SEESP_CMD_READ = 3'h1,
        SEESP_CMD_WRITE = 3'h2,
        SEESP_CMD_SFETCH = 3'h3,
        SEESP_CMD_SUPD = 3'h4
    } seesp_cmd_t;
    // Synchronised pin levels
    typedef struct packed {
        logic sel_n;
        logic sclk;
        logic mosi;
        logic hold_n;
        logic guard_n;
    } seesp_pins_t;
    // Received byte handed to the array side
    typedef struct packed {
        seesp_cmd_t cmd;
        logic [7:0] data;
    } seesp_word_t;
    typedef struct packed {
        seesp_pins_t s1;
        seesp_pins_t s2;
        seesp_pins_t p;
        logic armed;
        seesp_phase_t phase;
        seesp_cmd_t cmd;
        logic paused;
        logic [2:0] bitcnt;
        logic [7:0] shin;
        logic [7:0] shout;
        logic [7:0] tx_data;
        logic tx_ld;
        logic wel;
        logic guarded;
        logic miso;
        logic miso_oe;
        logic standby;
        logic prog_go;
        logic [1:0] bvld;
        seesp_word_t [1:0] buf_q;
        logic rd_ptr;
        logic wr_ptr;
    } seesp_state_t;
endpackage

/* File: design/seesp_front_end.sv */
/*
 Serial slave front end of a small serial EEPROM, sampled by mclk_i.
 Assumes the array and status blocks take received words through a
 two-entry buffer and supply read bytes and the busy flag.
*/
`timescale 1ns/1ns
`default_nettype none
`include "seesp_map.svh"
module seesp_front_end
    import seesp_pkg::*;
#(
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Serial pins
    input wire logic device_enable_n_i,
    input wire logic bit_strobe_i,
    input wire logic serial_in_i,
    input wire logic hold_n_i,
    input wire logic guard_pin_n_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    // Array side
    output logic rx_valid_o,
    output seesp_word_t rx_word_o,
    input wire logic rx_ready_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic prog_busy_i,
    output logic prog_start_o,
    output logic write_latch_o,
    output logic standby_o
);
    seesp_state_t q, d;

    function automatic seesp_cmd_t decode(input logic [7:0] b);
        unique case (b)
            `SEESP_OP_READ: decode = SEESP_CMD_READ;
            `SEESP_OP_WRITE: decode = SEESP_CMD_WRITE;
            `SEESP_OP_STAT_FETCH: decode = SEESP_CMD_SFETCH;
            `SEESP_OP_STAT_UPDATE: decode = SEESP_CMD_SUPD;
            default: decode = SEESP_CMD_NONE;
        endcase
    endfunction

    logic sel, rise, fall, hfall, hrise, gfall, desel, selfall, push;
    logic [7:0] byte_in;
    seesp_cmd_t opc;

    // ==========================================================
    // Next state
    always_comb begin
        d = q;
        d.s1 = '{device_enable_n_i, bit_strobe_i, serial_in_i, hold_n_i, guard_pin_n_i};
        d.s2 = q.s1;
        d.p = q.s2;
        d.prog_go = 1'b0;
        sel = !q.s2.sel_n;
        desel = q.s2.sel_n && !q.p.sel_n;
        selfall = !q.s2.sel_n && q.p.sel_n;
        rise = q.s2.sclk && !q.p.sclk;
        fall = !q.s2.sclk && q.p.sclk;
        hfall = !q.s2.hold_n && q.p.hold_n && !q.s2.sclk;
        hrise = q.s2.hold_n && !q.p.hold_n && !q.s2.sclk;
        // either idle level, edges found the same way
        gfall = !q.s2.guard_n && q.p.guard_n;
        byte_in = {q.shin[6:0], q.s2.mosi};
        opc = decode(byte_in);
        push = 1'b0;
        if (selfall) begin
            d.armed = 1'b1;
        end
        if (sel && hfall) begin
            d.paused = 1'b1;
        end else if (hrise) begin
            d.paused = 1'b0;
        end
        if (desel || !sel) begin
            d.phase = SEESP_IDLE;
            d.bitcnt = `SEESP_CNT_ZERO;
            d.cmd = SEESP_CMD_NONE;
            d.tx_ld = 1'b0;
            // write ends on byte boundary only
            if (desel && q.phase == SEESP_ACT && q.cmd != SEESP_CMD_READ &&
                q.cmd != SEESP_CMD_SFETCH && q.bitcnt == `SEESP_CNT_ZERO &&
                q.guarded && !prog_busy_i) begin
                d.prog_go = 1'b1;
                // latch drops after write or update
                d.wel = 1'b0;
            end
            d.guarded = 1'b0;
        end
        if (selfall) begin
            d.phase = SEESP_OPC;
        end
        if (sel && !q.paused && q.phase != SEESP_IDLE && q.phase != SEESP_WAIT) begin
            if (rise) begin
                d.shin = byte_in;
                d.bitcnt = q.bitcnt + 3'h1;
                if (q.bitcnt == `SEESP_BYTE_LAST) begin
                    push = 1'b1;
                    if (q.phase == SEESP_OPC) begin
                        if (byte_in == `SEESP_OP_SET_WL) begin
                            d.wel = 1'b1;
                            d.phase = SEESP_WAIT;
                            push = 1'b0;
                        end else if (byte_in == `SEESP_OP_CLR_WL) begin
                            d.wel = 1'b0;
                            d.phase = SEESP_WAIT;
                            push = 1'b0;
                        end else if (opc == SEESP_CMD_NONE) begin
                            d.phase = SEESP_WAIT;
                            push = 1'b0;
                        end else begin
                            d.cmd = opc;
                            d.phase = SEESP_ACT;
                            // write needs latch and guard high
                            d.guarded = q.wel && q.s2.guard_n &&
                                (opc == SEESP_CMD_WRITE || opc == SEESP_CMD_SUPD);
                            d.tx_ld = 1'b1;
                        end
                    end
                end
            end
            if (fall && q.phase == SEESP_ACT) begin
                if (q.bitcnt == `SEESP_CNT_ZERO && q.tx_ld) begin
                    d.shout = {q.tx_data[6:0], 1'b0};
                    d.miso = q.tx_data[7];
                    d.tx_ld = 1'b0;
                end else begin
                    d.shout = {q.shout[6:0], 1'b0};
                    d.miso = q.shout[7];
                end
                if (q.bitcnt == `SEESP_BYTE_LAST) begin
                    d.tx_ld = 1'b1;
                end
            end
        end
        if (tx_valid_i && !q.tx_ld) begin
            d.tx_data = tx_data_i;
        end
        // guard low clears latch, aborts write
        if (!q.s2.guard_n || gfall) begin
            d.wel = 1'b0;
            d.guarded = 1'b0;
        end
        // output drive only selected, active, not paused
        d.miso_oe = sel && !q.paused && q.phase == SEESP_ACT &&
            (q.cmd == SEESP_CMD_READ || q.cmd == SEESP_CMD_SFETCH);
        // standby while unselected and idle; programming keeps running
        d.standby = !sel && !prog_busy_i && !d.prog_go;
        // Receive buffer, a word pushed while both entries are still full is dropped
        if (q.bvld[q.rd_ptr] && rx_ready_i) begin
            d.bvld[q.rd_ptr] = 1'b0;
            d.rd_ptr = !q.rd_ptr;
        end
        if (push && !q.bvld[q.wr_ptr]) begin
            d.buf_q[q.wr_ptr] = '{opc != SEESP_CMD_NONE && q.phase == SEESP_OPC ?
                opc : q.cmd, byte_in};
            d.bvld[q.wr_ptr] = 1'b1;
            d.wr_ptr = !q.wr_ptr;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            q <= '0;
            // Synchroniser tracks the pins, so a select held low is no edge
            q.s1 <= d.s1;
            q.s2 <= d.s2;
            q.p <= d.p;
            q.standby <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign serial_out_o = q.miso;
    assign serial_out_oe_o = q.miso_oe;
    assign rx_valid_o = q.bvld[q.rd_ptr];
    assign rx_word_o = q.buf_q[q.rd_ptr];
    assign tx_ready_o = !q.tx_ld;
    assign prog_start_o = q.prog_go;
    assign write_latch_o = q.wel;
    assign standby_o = q.standby;

    // ==========================================================
    // Checks
    sequence set_seen;
        q.phase == SEESP_OPC && rise && !q.paused && sel &&
            q.bitcnt == `SEESP_BYTE_LAST && byte_in == `SEESP_OP_SET_WL;
    endsequence
    sequence clr_seen;
        q.phase == SEESP_OPC && rise && !q.paused && sel &&
            q.bitcnt == `SEESP_BYTE_LAST && byte_in == `SEESP_OP_CLR_WL;
    endsequence

    sequence bad_seen;
        q.phase == SEESP_OPC && rise && !q.paused && sel &&
            q.bitcnt == `SEESP_BYTE_LAST && opc == SEESP_CMD_NONE &&
            byte_in != `SEESP_OP_SET_WL && byte_in != `SEESP_OP_CLR_WL;
    endsequence

    chk_latch_set: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (set_seen and q.s2.guard_n) ##1 1'b1 |-> q.wel && q.phase == SEESP_WAIT)
        else $error("latch not set");

    chk_latch_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        clr_seen |=> !q.wel && q.phase == SEESP_WAIT)
        else $error("latch not cleared");

    chk_guard_clear: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !q.s2.guard_n |=> !q.wel)
        else $error("latch kept under guard");

    chk_guard_abort: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        gfall |=> !q.wel && !q.guarded)
        else $error("write kept after guard fall");

    chk_guard_block: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        q.guarded |-> $past(q.s2.guard_n))
        else $error("write armed under guard");

    chk_float_unsel: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        q.s2.sel_n |=> !serial_out_oe_o)
        else $error("drive while unselected");

    chk_standby_sel: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !q.s2.sel_n |=> !standby_o)
        else $error("standby while selected");

    chk_standby_go: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        prog_start_o |-> !standby_o)
        else $error("standby at program start");

    chk_prog_pulse: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        prog_start_o |=> !prog_start_o)
        else $error("program start too long");

    chk_float_pause: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        q.paused |=> !serial_out_oe_o)
        else $error("drive while paused");

    chk_bad_opcode: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        q.phase == SEESP_WAIT && sel && !q.s1.sel_n |=>
            q.phase == SEESP_WAIT && $stable(q.bitcnt))
        else $error("bus served after wait");

    chk_bad_wait: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        bad_seen |=> q.phase == SEESP_WAIT)
        else $error("bad opcode served");

    chk_wait_quiet: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        q.phase == SEESP_WAIT |-> !push)
        else $error("word pushed while waiting");

    chk_wait_float: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        q.phase == SEESP_WAIT |=> !serial_out_oe_o)
        else $error("drive while waiting");

    chk_pause_in: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(q.paused) |-> $past(sel) && !$past(q.s2.sclk))
        else $error("bad pause");

    chk_pause_out: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $fell(q.paused) |-> !$past(q.s2.sclk))
        else $error("bad resume");

    chk_pause_keep: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        desel && q.paused && !hrise |=> q.paused)
        else $error("pause lost on deselect");

    chk_sel_idle: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        q.s2.sel_n |=> q.phase == SEESP_IDLE)
        else $error("sequence kept while unselected");

    // select edge starts at bit zero
    chk_first_bit: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        selfall |=> q.phase == SEESP_OPC && q.bitcnt == `SEESP_CNT_ZERO)
        else $error("frame not started at bit zero");

    // output moves only after falling strobe
    chk_shift_out: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $changed(serial_out_o) |-> $past(fall))
        else $error("output moved off falling strobe");

    // Stalled word held until taken
    chk_buf_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_word_o))
        else $error("stalled word lost");

    chk_prog_gate: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        prog_start_o |-> $past(q.guarded) && !write_latch_o)
        else $error("bad program start");

    chk_armed: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !q.armed |-> q.phase == SEESP_IDLE)
        else $error("active before first select");

    chk_armed_stay: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        q.armed |=> q.armed)
        else $error("arming lost");
endmodule
`default_nettype wire

/* File: verif/seesp_spi_master.sv */
/*
 SPI master model driving the serial pins of the front end.
 Assumes a 10 ns mclk_i; each strobe phase lasts 4 cycles (80 ns period).
*/
`timescale 1ns/1ns
`default_nettype none
module seesp_spi_master (
    // Clock
    input wire logic mclk_i,
    // Serial pins
    output logic sel_n_o,
    output logic sclk_o,
    output logic mosi_o,
    output logic hold_n_o,
    input wire logic miso_i
);
    initial begin
        sel_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        hold_n_o = 1'b1;
    end
    task automatic half();
        repeat (4) @(posedge mclk_i);
    endtask
    task automatic select(input logic pol);
        sclk_o <= pol;
        half();
        sel_n_o <= 1'b0;
        half();
    endtask
    // hold moves only with strobe low
    task automatic pause();
        half();
        hold_n_o <= 1'b0;
        half();
        sclk_o <= 1'b1;
        mosi_o <= ~mosi_o;
        half();
        sclk_o <= 1'b0;
        half();
        hold_n_o <= 1'b1;
    endtask
    // msb first, caller sends opcode first
    task automatic xfer(input logic [7:0] tx, input int pz, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk_o <= 1'b0;
            if (i == pz) pause();
            mosi_o <= tx[i];
            half();
            sclk_o <= 1'b1;
            half();
            rx[i] = miso_i;
        end
    endtask
    // Released data line shows garbage, not the last bit
    task automatic deselect(input logic pol);
        sclk_o <= pol;
        half();
        sel_n_o <= 1'b1;
        mosi_o <= ~mosi_o;
        half();
    endtask
endmodule
`default_nettype wire

/* File: verif/seesp_front_end_tb.sv */
/*
 Self-checking bench of the serial EEPROM front end.
 Assumes seesp_pkg and the master model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module seesp_front_end_tb;
    import seesp_pkg::*;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic sel_n, sclk, mosi, hold_n, miso, oe, rx_valid, prog, latch, stby;
    logic guard_n = 1'b1;
    logic rx_ready = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic busy = 1'b0;
    seesp_word_t rx_word;
    logic [7:0] rxq[$];
    logic [7:0] last_rx, op, a, d;
    logic lat;
    int seed = 32;
    int mismatches = 0;
    int check_count = 0;
    int prog_cnt = 0;
    int cycles = 0;
    int n;
    always #5 mclk_i = ~mclk_i;
    seesp_front_end seesp_front_end_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .device_enable_n_i(sel_n), .bit_strobe_i(sclk), .serial_in_i(mosi),
        .hold_n_i(hold_n), .guard_pin_n_i(guard_n), .serial_out_o(miso),
        .serial_out_oe_o(oe), .rx_valid_o(rx_valid), .rx_word_o(rx_word),
        .rx_ready_i(rx_ready), .tx_data_i(tx_data), .tx_valid_i(1'b1), .tx_ready_o(),
        .prog_busy_i(busy), .prog_start_o(prog), .write_latch_o(latch),
        .standby_o(stby));
    seesp_spi_master seesp_spi_master_i (.mclk_i(mclk_i), .sel_n_o(sel_n),
        .sclk_o(sclk), .mosi_o(mosi), .hold_n_o(hold_n), .miso_i(miso));
    // ========
    // Checking helpers
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", what, e, g);
        end
    endtask
    task automatic latch_is(input logic e);
        chk("write_latch", {7'h00, e}, {7'h00, latch});
    endtask
    function automatic logic exp_latch(input logic [7:0] o, input logic g, input logic p);
        if (!g || o == 8'h04) return 1'b0;
        return (o == 8'h06) ? 1'b1 : p;
    endfunction
    task automatic frame(input logic pol, input int k, input logic [23:0] b, input int pz);
        seesp_spi_master_i.select(pol);
        for (int i = 0; i < k; i++) begin
            seesp_spi_master_i.xfer(b[23-8*i -: 8], (i == 0) ? pz : -1, last_rx);
        end
        seesp_spi_master_i.deselect(pol);
        repeat (8) @(posedge mclk_i);
    endtask
    // Consumer stalls at random; a ceiling cuts a hang short
    always @(posedge mclk_i) begin
        cycles++;
        rx_ready <= 1'($random(seed));
        if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_word.data);
        if (prog === 1'b1) prog_cnt++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    // ========
    // Scenarios
    initial begin
        seesp_spi_master_i.select(1'b0);
        repeat (4) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        seesp_spi_master_i.xfer(8'h06, -1, last_rx);
        seesp_spi_master_i.deselect(1'b0);
        latch_is(1'b0);
        $display("test power_on done");
        lat = 1'b0;
        for (int k = 0; k < 16; k++) begin
            op = (k < 4) ? ((k % 2) ? 8'h04 : 8'h06) : 8'($random(seed));
            if (op == 8'h01 || op == 8'h02) op = 8'hff;
            guard_n <= (k < 4) ? 1'b1 : 1'($random(seed)) | k[0];
            frame(k[1], 1, {op, 16'h0000}, -1);
            lat = exp_latch(op, guard_n, lat);
            latch_is(lat);
        end
        guard_n <= 1'b1;
        frame(1'b0, 2, 24'h06_0400, -1);
        latch_is(1'b1);
        frame(1'b1, 2, 24'ha5_0400, -1);
        latch_is(1'b1);
        chk("oe_idle", 8'h00, {7'h00, oe});
        chk("standby", 8'h01, {7'h00, stby});
        $display("test opcodes done");
        a = 8'($random(seed));
        d = 8'($random(seed));
        n = prog_cnt;
        frame(1'b0, 3, {8'h02, a, d}, -1);
        chk("prog_count", 8'(n + 1), 8'(prog_cnt));
        latch_is(1'b0);
        chk("rx_addr", a, rxq[rxq.size() - 2]);
        chk("rx_data", d, rxq[rxq.size() - 1]);
        frame(1'b1, 3, {8'h02, a, d}, -1);
        chk("prog_nolatch", 8'(n + 1), 8'(prog_cnt));
        frame(1'b0, 1, 24'h06_0000, -1);
        fork
            frame(1'b0, 3, {8'h02, a, d}, -1);
            begin
                repeat (150) @(posedge mclk_i);
                guard_n <= 1'b0;
            end
        join
        chk("prog_guard", 8'(n + 1), 8'(prog_cnt));
        latch_is(1'b0);
        guard_n <= 1'b1;
        $display("test write done");
        tx_data <= 8'($random(seed));
        frame(1'b1, 3, {8'h03, a, 8'h00}, -1);
        chk("read_byte", tx_data, last_rx);
        frame(1'b0, 1, 24'h06_0000, 3);
        latch_is(1'b1);
        busy <= 1'b1;
        repeat (8) @(posedge mclk_i);
        chk("standby_busy", 8'h00, {7'h00, stby});
        busy <= 1'b0;
        $display("test read_pause done");
        final_report();
    end
endmodule
`default_nettype wire
